// ===== hw/ptm_period_timer.sv
// apb period timer: prescaler, 8-bit counter with period match, postscaler
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps

// Overview of operation
// [R01] The count clock is pclk/4 divided again by 1, 4 or 16 as input_divide_select picks.
// [R02] The counter rises from zero until it equals the period value, then wraps to zero.
// [R03] The period register is read/write and resets to all ones.
// [R04] Software reads and writes the counter, and any reset clears it.
// [R05] Matches pass a 1..16 postscaler before setting the period event flag, bit 1.
// [R06] The timer counts only while the run bit, control bit 2, is one.
// [R07] Writing the counter or control, or reset, clears prescaler and postscaler.
// [R08] Writing the control register leaves the counter value as it was.
// [R09] The raw match pulse goes out as a shift clock source for the serial port.
// [R10] The count and the raw match are offered as a pwm time base.
// [R11] The event flag stays set until software writes zero to it.
module ptm_period_timer (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ptm_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    output logic                           irq,
    output logic                           ser_shift_clk_pulse,
    output logic      [7:0]                pwm_timebase_count,
    output logic                           pwm_period_match
);
    ptm_pkg::ptm_top_state_s st_reg;
    ptm_pkg::ptm_top_state_s st_next;

    logic       setup_phase;
    logic       access_done;
    logic       wr_count;
    logic       wr_ctrl;
    logic       wr_period;
    logic       wr_flag;
    logic       wr_enable;
    logic       scaler_clr;
    logic       inst_tick;
    logic       pre_tick;
    logic       match_raw;
    logic       post_tick;
    logic       event_flag;
    logic       event_mask;
    logic [3:0] pre_ratio_m1;

    // ************************************************************
    // bus decode
    // ************************************************************
    // writes land only on the edge that completes the access phase
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && st_reg.pready;
    assign wr_count    = access_done && pwrite && (paddr == ptm_pkg::COUNT_OFS);
    assign wr_ctrl     = access_done && pwrite && (paddr == ptm_pkg::CONTROL_OFS);
    assign wr_period   = access_done && pwrite && (paddr == ptm_pkg::PERIOD_OFS);
    assign wr_flag     = access_done && pwrite && (paddr == ptm_pkg::FLAG_OFS);
    assign wr_enable   = access_done && pwrite && (paddr == ptm_pkg::ENABLE_OFS);

    // counter or control writes restart both scalers
    assign scaler_clr = wr_count || wr_ctrl;                    // [R07]

    // ************************************************************
    // clock chain
    // ************************************************************
    // instruction rate enable, free running so writes do not skew it
    ptm_rate_div u_inst_div (
        .pclk     (pclk),
        .presetn  (presetn),
        .en       (1'b1),
        .clr      (1'b0),
        .ratio_m1 (ptm_pkg::INST_DIV_M1),                      // [R01]
        .tick     (inst_tick)
    );

    // prescale select: 00 -> 1, 01 -> 4, 1x -> 16
    always_comb begin
        if (st_reg.ctrl.input_divide_select[1]) begin
            pre_ratio_m1 = ptm_pkg::PRE16_M1;                   // [R01]
        end else if (st_reg.ctrl.input_divide_select[0]) begin
            pre_ratio_m1 = ptm_pkg::PRE4_M1;                    // [R01]
        end else begin
            pre_ratio_m1 = ptm_pkg::PRE1_M1;                    // [R01]
        end
    end

    // gating the prescaler halts prescaler, counter and postscaler while the run bit is low
    ptm_rate_div u_prescaler (
        .pclk     (pclk),
        .presetn  (presetn),
        .en       (inst_tick && st_reg.ctrl.slot_timer_run),    // [R06]
        .clr      (scaler_clr),                                 // [R07]
        .ratio_m1 (pre_ratio_m1),
        .tick     (pre_tick)
    );

    // a counter write in the same cycle wins and suppresses the match
    assign match_raw = pre_tick && !wr_count && (st_reg.count == st_reg.period);

    ptm_rate_div u_postscaler (
        .pclk     (pclk),
        .presetn  (presetn),
        .en       (match_raw),
        .clr      (scaler_clr),                                 // [R07]
        .ratio_m1 (st_reg.ctrl.match_divide_select),            // [R05]
        .tick     (post_tick)
    );

    // ************************************************************
    // event flag and interrupt
    // ************************************************************
    ptm_event_flag u_event (
        .pclk       (pclk),
        .presetn    (presetn),
        .set_pulse  (post_tick),                                // [R05]
        .flag_wr    (wr_flag),
        .flag_wdata (pwdata[ptm_pkg::EVENT_BIT]),               // [R11]
        .mask_wr    (wr_enable),
        .mask_wdata (pwdata[ptm_pkg::EVENT_BIT]),
        .flag       (event_flag),
        .mask       (event_mask),
        .irq        (irq)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_next         = st_reg;
        st_next.match   = match_raw;                            // [R09] [R10]
        st_next.pready  = 1'b0;
        st_next.pslverr = 1'b0;

        // counter: software write first, then wrap on match, else count up
        if (wr_count) begin
            st_next.count = pwdata[7:0];                        // [R04]
        end else if (match_raw) begin
            st_next.count = ptm_pkg::COUNT_RESET;               // [R02]
        end else if (pre_tick) begin
            st_next.count = st_reg.count + 8'h01;               // [R02]
        end

        // control write sets the control bits and restarts both scalers, never the count
        if (wr_ctrl) begin
            st_next.ctrl = ptm_pkg::ptm_ctrl_s'(pwdata[6:0]);   // [R08]
        end
        if (wr_period) begin
            st_next.period = pwdata[7:0];                       // [R03]
        end

        // answer one cycle after setup; read data captured at setup
        if (setup_phase) begin
            st_next.pready = 1'b1;
            st_next.prdata = 32'h0000_0000;
            if (paddr == ptm_pkg::FLAG_OFS) begin
                st_next.prdata[ptm_pkg::EVENT_BIT] = event_flag;
            end else if (paddr == ptm_pkg::ENABLE_OFS) begin
                st_next.prdata[ptm_pkg::EVENT_BIT] = event_mask;
            end else if (paddr == ptm_pkg::COUNT_OFS) begin
                st_next.prdata[7:0] = st_reg.count;             // [R04]
            end else if (paddr == ptm_pkg::CONTROL_OFS) begin
                st_next.prdata[6:0] = st_reg.ctrl;
            end else if (paddr == ptm_pkg::PERIOD_OFS) begin
                st_next.prdata[7:0] = st_reg.period;            // [R03]
            end else begin
                st_next.pslverr = 1'b1;                         // unmapped
            end
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg         <= '0;
            st_reg.count   <= ptm_pkg::COUNT_RESET;             // [R04]
            st_reg.period  <= ptm_pkg::PERIOD_RESET;            // [R03]
            st_reg.ctrl    <= ptm_pkg::CONTROL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state flops
    assign prdata              = st_reg.prdata;
    assign pready              = st_reg.pready;
    assign pslverr             = st_reg.pslverr;
    assign ser_shift_clk_pulse = st_reg.match;                  // [R09]
    assign pwm_period_match    = st_reg.match;                  // [R10]
    assign pwm_timebase_count  = st_reg.count;                  // [R10]

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_count_wrap: assert property (                                  // [R02]
        (pre_tick && !wr_count && st_reg.count == st_reg.period)
        |=> st_reg.count == 8'h00 && ser_shift_clk_pulse && pwm_period_match)
        else $error("counter did not wrap on period match");

    a_count_incr: assert property (                                  // [R02]
        (pre_tick && !wr_count && st_reg.count != st_reg.period)
        |=> st_reg.count == $past(st_reg.count) + 8'h01 && !ser_shift_clk_pulse)
        else $error("counter did not increment");

    a_count_write: assert property (                                 // [R04]
        wr_count |=> pwm_timebase_count == $past(pwdata[7:0]))
        else $error("counter write lost");

    a_period_write: assert property (                                // [R03]
        // read of the period after one idle cycle returns the written byte
        wr_period ##2 (psel && !penable && paddr == ptm_pkg::PERIOD_OFS && !pwrite)
        |=> prdata[7:0] == $past(pwdata[7:0], 3))
        else $error("period value not stored");

    a_ctrl_keeps: assert property (                                  // [R08]
        (wr_ctrl && !pre_tick) |=> $stable(st_reg.count))
        else $error("control write changed counter");

    a_run_off: assert property (                                     // [R06]
        (!st_reg.ctrl.slot_timer_run && !wr_count) |=> $stable(st_reg.count))
        else $error("counter moved while stopped");

    a_prescale_one: assert property (                                // [R01]
        (st_reg.ctrl == ptm_pkg::ptm_ctrl_s'(7'h04) && !scaler_clr && inst_tick)
        |-> pre_tick)
        else $error("divide-by-one prescale missed a tick");

    a_apb_answer: assert property (                                  // apb timing
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");

endmodule : ptm_period_timer

// ===== hw/ptm_pkg.sv
// shared constants, register map and state types of the period timer
package ptm_pkg;

    // ************************************************************
    // clock and rates
    // ************************************************************
    localparam int unsigned PCLK_MHZ   = 250;      // oscillator rate seen as pclk
    localparam int unsigned FOSC_DIV   = 4;        // instruction rate is pclk / 4
    localparam int unsigned DIV_W      = 4;        // width of every scaler counter
    localparam logic [3:0]  INST_DIV_M1 = 4'(FOSC_DIV - 1);
    localparam logic [3:0]  PRE1_M1    = 4'h0;     // input divide 1
    localparam logic [3:0]  PRE4_M1    = 4'h3;     // input divide 4
    localparam logic [3:0]  PRE16_M1   = 4'hF;     // input divide 16

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam int unsigned ADDR_W         = 12;
    localparam logic [11:0] FLAG_OFS       = 12'h00C;  // peripheral_flag_reg
    localparam logic [11:0] ENABLE_OFS     = 12'h08C;  // peripheral_enable_reg
    localparam logic [11:0] COUNT_OFS      = 12'h010;  // slot_timer_count
    localparam logic [11:0] CONTROL_OFS    = 12'h014;  // slot_timer_control
    localparam logic [11:0] PERIOD_OFS     = 12'h018;  // period_match_value
    localparam int unsigned EVENT_BIT      = 1;        // period_event_flag / _enable
    localparam logic [7:0]  COUNT_RESET    = 8'h00;
    localparam logic [7:0]  PERIOD_RESET   = 8'hFF;
    localparam logic [6:0]  CONTROL_RESET  = 7'h00;

    // ************************************************************
    // types
    // ************************************************************
    // control register bits 6..0; bit 7 reads zero
    typedef struct packed {
        logic [3:0] match_divide_select;
        logic       slot_timer_run;
        logic [1:0] input_divide_select;
    } ptm_ctrl_s;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
    } ptm_div_state_s;

    typedef struct packed {
        logic flag;
        logic mask;
        logic irq;
    } ptm_event_state_s;

    typedef struct packed {
        ptm_ctrl_s   ctrl;
        logic [7:0]  count;
        logic [7:0]  period;
        logic        match;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ptm_top_state_s;

endpackage : ptm_pkg

// ===== hw/ptm_rate_div.sv
// divide-by-n enable generator with synchronous clear
`timescale 1ns/1ps
module ptm_rate_div (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    en,
    input  wire logic                    clr,
    input  wire logic [ptm_pkg::DIV_W-1:0] ratio_m1,
    output logic                         tick
);
    ptm_pkg::ptm_div_state_s st_reg;
    ptm_pkg::ptm_div_state_s st_next;

    // ************************************************************
    // counter
    // ************************************************************
    // one tick every ratio_m1+1 enabled cycles
    assign tick = en && !clr && (st_reg.cnt == ratio_m1);

    // clear wins over counting so a write restarts the ratio cleanly
    always_comb begin
        st_next = st_reg;
        if (clr) begin
            st_next.cnt = '0;                                   // [R07]
        end else if (en) begin
            st_next.cnt = tick ? '0 : st_reg.cnt + 4'h1;        // [R01] [R05]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;                                       // [R07]
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_clear_restart: assert property (clr |=> st_reg.cnt == 4'h0) // [R07]
        else $error("scaler not cleared");
    a_tick_ratio: assert property (                                  // [R01]
        (en && !clr && st_reg.cnt != ratio_m1 && $stable(ratio_m1))
        |=> st_reg.cnt == $past(st_reg.cnt) + 4'h1)
        else $error("scaler did not advance");

endmodule : ptm_rate_div

// ===== hw/ptm_event_flag.sv
// sticky period event flag, its enable and the interrupt level
`timescale 1ns/1ps
module ptm_event_flag (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic set_pulse,
    input  wire logic flag_wr,
    input  wire logic flag_wdata,
    input  wire logic mask_wr,
    input  wire logic mask_wdata,
    output logic      flag,
    output logic      mask,
    output logic      irq
);
    ptm_pkg::ptm_event_state_s st_reg;
    ptm_pkg::ptm_event_state_s st_next;

    // ************************************************************
    // flag and mask
    // ************************************************************
    // a hardware set in the write cycle wins so no event is lost
    always_comb begin
        st_next = st_reg;
        if (flag_wr) begin
            st_next.flag = flag_wdata;                   // [R11]
        end
        if (set_pulse) begin
            st_next.flag = 1'b1;                         // [R05] [R11]
        end
        if (mask_wr) begin
            st_next.mask = mask_wdata;
        end
        st_next.irq = st_next.flag && st_next.mask;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flag = st_reg.flag;
    assign mask = st_reg.mask;
    assign irq  = st_reg.irq;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_flag_sticky: assert property ((flag && !flag_wr) |=> flag) // [R11]
        else $error("event flag dropped without a write");
    a_flag_set: assert property (set_pulse |=> flag && (irq == mask)) // [R05]
        else $error("event flag not set by postscaler");

endmodule : ptm_event_flag

// ===== verification/ptm_period_timer_tb_top.sv
// self-checking testbench of the apb period timer
`timescale 1ns/1ps
module ptm_period_timer_tb_top;

    // ************************************************************
    // signals and design instance
    // ************************************************************
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        ser_pulse;
    logic [7:0]  pwm_count;
    logic        pwm_match;
    int          n_fail   = 0;
    int          n_checks = 0;

    ptm_period_timer dut (
        .pclk                (pclk),
        .presetn             (presetn),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .paddr               (paddr),
        .pwdata              (pwdata),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr),
        .irq                 (irq),
        .ser_shift_clk_pulse (ser_pulse),
        .pwm_timebase_count  (pwm_count),
        .pwm_period_match    (pwm_match)
    );

    // 250 MHz clock
    always #2 pclk = ~pclk;

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // one apb transfer; entered just after a rising edge, leaves one idle edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) check(32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        check(rd, exp);
        check({31'h0, err}, 32'h0);
    endtask : rd_chk

    // cycles until the next raw match pulse, bounded
    task automatic wait_pulse(output int cyc);
        cyc = 0;
        do begin
            @(posedge pclk);
            cyc++;
        end while (ser_pulse !== 1'b1 && cyc < 5000);
        // a pulse that never came counts as a mismatch
        if (cyc >= 5000) check(32'h0, 32'h1);
    endtask : wait_pulse

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset_values();
        logic [31:0] rd;
        logic        err;
        rd_chk(ptm_pkg::FLAG_OFS, 32'h0);
        rd_chk(ptm_pkg::ENABLE_OFS, 32'h0);
        rd_chk(ptm_pkg::COUNT_OFS, 32'h0);
        rd_chk(ptm_pkg::CONTROL_OFS, 32'h0);
        rd_chk(ptm_pkg::PERIOD_OFS, 32'hFF);
        // unmapped word: error, zero data, write dropped
        wr(12'h020, 32'hFFFF_FFFF);
        apb(1'b0, 12'h020, 32'h0, rd, err);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        // bit 7 of control is unimplemented
        wr(ptm_pkg::CONTROL_OFS, 32'hFF);
        rd_chk(ptm_pkg::CONTROL_OFS, 32'h7F);
        wr(ptm_pkg::PERIOD_OFS, 32'h1A5);
        rd_chk(ptm_pkg::PERIOD_OFS, 32'hA5);
        wr(ptm_pkg::CONTROL_OFS, 32'h0);
    endtask : t_reset_values

    task automatic t_prescale();
        int cyc;
        int dv;
        wr(ptm_pkg::PERIOD_OFS, 32'h2);
        for (int c = 0; c < 4; c++) begin
            dv = (c == 0) ? 1 : (c == 1) ? 4 : 16;
            wr(ptm_pkg::CONTROL_OFS, {29'h0, 1'b1, 2'(c)});
            wait_pulse(cyc);
            wait_pulse(cyc);
            check(32'(cyc), 32'(3 * 4 * dv));
            check({24'h0, pwm_count}, 32'h0);
            check({31'h0, pwm_match}, 32'h1);
            // the raw match is a single-cycle pulse
            @(posedge pclk);
            check({31'h0, ser_pulse}, 32'h0);
        end
        wr(ptm_pkg::CONTROL_OFS, 32'h0);
    endtask : t_prescale

    task automatic t_postscale();
        int cyc;
        int m;
        int sel[3] = '{0, 2, 15};
        wr(ptm_pkg::PERIOD_OFS, 32'h9);
        for (int i = 0; i < 3; i++) begin
            m = sel[i];
            wr(ptm_pkg::CONTROL_OFS, 32'h0);
            wr(ptm_pkg::FLAG_OFS, 32'h0);
            // control write also restarts the postscaler
            wr(ptm_pkg::CONTROL_OFS, {25'h0, 4'(m), 1'b1, 2'b00});
            for (int k = 1; k <= m + 1; k++) begin
                wait_pulse(cyc);
                if (k == m) rd_chk(ptm_pkg::FLAG_OFS, 32'h0);
            end
            rd_chk(ptm_pkg::FLAG_OFS, 32'h2);
        end
        wait_pulse(cyc);
        rd_chk(ptm_pkg::FLAG_OFS, 32'h2);
        // interrupt level follows flag and enable
        wr(ptm_pkg::ENABLE_OFS, 32'h2);
        check({31'h0, irq}, 32'h1);
        wr(ptm_pkg::ENABLE_OFS, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(ptm_pkg::ENABLE_OFS, 32'h2);
        wr(ptm_pkg::CONTROL_OFS, 32'h0);
        wr(ptm_pkg::FLAG_OFS, 32'h0);
        check({31'h0, irq}, 32'h0);
        rd_chk(ptm_pkg::FLAG_OFS, 32'h0);
    endtask : t_postscale

    task automatic t_stopped();
        logic [7:0] v;
        v = pwm_count;
        repeat (200) @(posedge pclk);
        check({24'h0, pwm_count}, {24'h0, v});
    endtask : t_stopped

    task automatic t_scaler_clear();
        int cyc;
        logic moved;
        moved = 1'b0;
        wr(ptm_pkg::PERIOD_OFS, 32'hFF);
        wr(ptm_pkg::COUNT_OFS, 32'h10);
        wr(ptm_pkg::CONTROL_OFS, 32'h6);
        // rewrites closer than one /16 step: an uncleared prescaler would move it
        repeat (3) begin
            repeat (40) begin
                @(posedge pclk);
                if (pwm_count !== 8'h10) moved = 1'b1;
            end
            wr(ptm_pkg::COUNT_OFS, 32'h10);
        end
        check({31'h0, moved}, 32'h0);
        cyc = 0;
        do begin
            @(posedge pclk);
            cyc++;
        end while (pwm_count === 8'h10 && cyc < 200);
        check({31'h0, 1'(cyc >= 56 && cyc <= 68)}, 32'h1);
        check({24'h0, pwm_count}, 32'h11);
        // control write keeps the count
        wr(ptm_pkg::CONTROL_OFS, 32'h0);
        wr(ptm_pkg::COUNT_OFS, 32'h5A);
        wr(ptm_pkg::CONTROL_OFS, 32'h7A);
        rd_chk(ptm_pkg::COUNT_OFS, 32'h5A);
        rd_chk(ptm_pkg::CONTROL_OFS, 32'h7A);
        wr(ptm_pkg::CONTROL_OFS, 32'h0);
    endtask : t_scaler_clear

    task automatic t_mid_reset();
        wr(ptm_pkg::PERIOD_OFS, 32'h33);
        wr(ptm_pkg::COUNT_OFS, 32'h44);
        wr(ptm_pkg::CONTROL_OFS, 32'h5);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(ptm_pkg::PERIOD_OFS, 32'hFF);
        rd_chk(ptm_pkg::COUNT_OFS, 32'h0);
        rd_chk(ptm_pkg::CONTROL_OFS, 32'h0);
    endtask : t_mid_reset

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_values();
        t_prescale();
        t_postscale();
        t_stopped();
        t_scaler_clear();
        t_mid_reset();
        stop_test();
    end

    // whole run is near 2500 cycles; allow twenty times that
    initial begin
        #200000;
        check(32'h0, 32'h1);
        stop_test();
    end

endmodule : ptm_period_timer_tb_top
